//--- design/tc16_regs.sv
// Timer counter control, compare, capture and interrupt register set
`timescale 1ns/1ns
`default_nettype none
module tc16_regs (
    input wire logic i_clock,
    input wire logic i_rst_n,
    input wire logic [3:0] i_addr,
    input wire logic i_wr,
    input wire logic i_rd,
    input wire logic [7:0] i_wdata,
    output logic [7:0] o_rdata,
    input wire logic i_capture_pin,
    input wire logic i_comparator_out,
    input wire logic i_capture_from_comparator,
    input wire logic i_ext_count_pin,
    input wire logic i_global_irq_en,
    input wire logic [3:0] i_vec_ack,
    output logic [3:0] o_irq_req,
    output logic [1:0] o_compare_out,
    output logic [1:0] o_compare_out_en
);
    // ----------------------------------------
    // State
    // ----------------------------------------
    logic [7:0] ctrl_a, ctrl_b, imsk, flags, temp;
    logic [7:0] next_ctrl_a, next_ctrl_b, next_imsk, next_flags, next_temp;
    logic [7:0] next_rdata;
    logic [15:0] count, icr, next_count, next_icr;
    logic [15:0] ocr [2];
    logic [15:0] next_ocr [2];
    logic down, block, next_down, next_block;
    logic [1:0] next_out, next_out_en;
    logic [3:0] next_irq;

    // ----------------------------------------
    // Mode decode
    // ----------------------------------------
    logic [3:0] mode;
    logic [15:0] top;
    logic is_fast, is_phase, icr_top, non_pwm, at_top;
    logic tick, cap_event, cap_src;
    logic wr_c, cnt_commit;
    logic [1:0] hit, force_cmp;

    assign mode = {ctrl_b[4:3], ctrl_a[1:0]};

    always_comb begin
        is_phase = mode inside {4'h1, 4'h2, 4'h3, 4'h8, 4'h9, 4'hA, 4'hB}; // R18
        is_fast = mode inside {4'h5, 4'h6, 4'h7, 4'hE, 4'hF}; // R18
        icr_top = mode inside {4'h8, 4'hA, 4'hC, 4'hE}; // R18
        non_pwm = !is_phase && !is_fast;
        case (mode)
            4'h1, 4'h5: top = tc16_pkg::TOP_8;
            4'h2, 4'h6: top = tc16_pkg::TOP_9;
            4'h3, 4'h7: top = tc16_pkg::TOP_10;
            4'h4, 4'h9, 4'hB, 4'hF: top = ocr[0];
            4'h8, 4'hA, 4'hC, 4'hE: top = icr;
            default: top = tc16_pkg::TOP_MAX;
        endcase
        at_top = count == top;
    end

    // ----------------------------------------
    // Count source and capture input
    // ----------------------------------------
    tc16_prescale u_prescale (
        .i_clock(i_clock),
        .i_rst_n(i_rst_n),
        .i_sel(ctrl_b[2:0]),
        .i_ext_count_pin(i_ext_count_pin),
        .o_tick(tick)
    );

    assign cap_src = i_capture_from_comparator ? i_comparator_out : i_capture_pin; // R15

    tc16_capture u_capture (
        .i_clock(i_clock),
        .i_rst_n(i_rst_n),
        .i_in(cap_src),
        .i_filter_en(ctrl_b[tc16_pkg::B_NOISE]),
        .i_edge_sel(ctrl_b[tc16_pkg::B_EDGE]),
        .o_event(cap_event)
    );

    assign wr_c = i_wr && i_addr == tc16_pkg::A_CTRL_C;
    assign cnt_commit = i_wr && i_addr == tc16_pkg::A_CNT_L;

    // ----------------------------------------
    // Compare channels, A is index 0
    // ----------------------------------------
    genvar g;
    generate
        for (g = 0; g < 2; g++) begin : g_ch
            logic [1:0] act;
            logic tog_ok;
            assign act = ctrl_a[7-2*g -: 2];
            assign hit[g] = tick && count == ocr[g] && !block; // R13 R14
            // Force is ignored in PWM modes, where software keeps it zero anyway
            assign force_cmp[g] = wr_c && i_wdata[tc16_pkg::B_FORCE_A-g] && non_pwm; // R8 R11
            assign tog_ok = (g == 0) && (mode inside {4'h8, 4'h9, 4'hA, 4'hB, 4'hE, 4'hF});
            always_comb begin
                next_out[g] = o_compare_out[g];
                next_out_en[g] = act != 2'b00;
                if (non_pwm) begin
                    if (hit[g] || force_cmp[g]) begin
                        case (act)
                            2'b01: next_out[g] = ~o_compare_out[g]; // R19
                            2'b10: next_out[g] = 1'b0; // R19
                            2'b11: next_out[g] = 1'b1; // R19
                            default: next_out[g] = o_compare_out[g];
                        endcase
                    end
                end else if (act[1]) begin
                    if (is_fast && tick && at_top) begin
                        next_out[g] = ~act[0];
                    end else if (hit[g]) begin
                        next_out[g] = (is_phase && down) ? ~act[0] : act[0];
                    end
                end else if (act[0] && tog_ok) begin
                    if (hit[g]) begin
                        next_out[g] = ~o_compare_out[g];
                    end
                end else begin
                    next_out_en[g] = 1'b0;
                end
            end
        end
    endgenerate

    // ----------------------------------------
    // Counter, registers, flags, read data
    // ----------------------------------------
    always_comb begin
        next_ctrl_a = ctrl_a;
        next_ctrl_b = ctrl_b;
        next_imsk = imsk;
        next_temp = temp;
        next_count = count;
        next_icr = icr;
        next_ocr = ocr;
        next_down = down;
        next_block = block;
        next_rdata = o_rdata;
        next_flags = flags;
        if (tick) begin
            next_block = 1'b0;
            if (is_phase) begin
                if (!down) begin
                    if (at_top) begin
                        next_down = 1'b1;
                        next_count = count - 16'h0001;
                    end else begin
                        next_count = count + 16'h0001;
                    end
                end else if (count == 16'h0000) begin
                    next_down = 1'b0;
                    next_count = count + 16'h0001;
                    next_flags[tc16_pkg::B_OVF] = 1'b1;
                end else begin
                    next_count = count - 16'h0001;
                end
            end else if (at_top) begin
                next_count = 16'h0000;
                next_down = 1'b0;
                if (is_fast || count == tc16_pkg::TOP_MAX) begin
                    next_flags[tc16_pkg::B_OVF] = 1'b1;
                end
            end else begin
                next_count = count + 16'h0001;
                next_down = 1'b0;
                if (count == tc16_pkg::TOP_MAX) begin
                    next_flags[tc16_pkg::B_OVF] = 1'b1;
                end
            end
            if (icr_top && at_top) begin
                next_flags[tc16_pkg::B_CAP] = 1'b1;
            end
        end
        if (i_rd) begin
            case (i_addr)
                tc16_pkg::A_CTRL_A: next_rdata = ctrl_a;
                tc16_pkg::A_CTRL_B: next_rdata = ctrl_b;
                tc16_pkg::A_CNT_L: next_rdata = count[7:0]; // R12 R22
                tc16_pkg::A_OCA_L: next_rdata = ocr[0][7:0];
                tc16_pkg::A_OCB_L: next_rdata = ocr[1][7:0];
                tc16_pkg::A_ICR_L: next_rdata = icr[7:0];
                tc16_pkg::A_CNT_H, tc16_pkg::A_OCA_H, tc16_pkg::A_OCB_H, tc16_pkg::A_ICR_H: next_rdata = temp;
                tc16_pkg::A_MASK: next_rdata = imsk;
                tc16_pkg::A_FLAG: next_rdata = flags;
                default: next_rdata = tc16_pkg::RST_BYTE; // R10
            endcase
            case (i_addr)
                tc16_pkg::A_CNT_L: next_temp = count[15:8]; // R22
                tc16_pkg::A_OCA_L: next_temp = ocr[0][15:8];
                tc16_pkg::A_OCB_L: next_temp = ocr[1][15:8];
                tc16_pkg::A_ICR_L: next_temp = icr[15:8];
                default: next_temp = temp;
            endcase
        end
        if (i_wr) begin
            case (i_addr)
                tc16_pkg::A_CTRL_A: next_ctrl_a = i_wdata;
                tc16_pkg::A_CTRL_B: begin
                    next_ctrl_b = i_wdata;
                    next_ctrl_b[tc16_pkg::B_RETRIG] = 1'b0; // R5
                end
                tc16_pkg::A_CNT_L: begin
                    next_count = {temp, i_wdata}; // R12 R22
                    next_block = 1'b1; // R13
                end
                tc16_pkg::A_OCA_L: next_ocr[0] = {temp, i_wdata};
                tc16_pkg::A_OCB_L: next_ocr[1] = {temp, i_wdata};
                tc16_pkg::A_ICR_L: next_icr = {temp, i_wdata};
                tc16_pkg::A_CNT_H, tc16_pkg::A_OCA_H, tc16_pkg::A_OCB_H, tc16_pkg::A_ICR_H: next_temp = i_wdata;
                tc16_pkg::A_MASK: next_imsk = i_wdata & tc16_pkg::IRQ_BITS; // R17
                tc16_pkg::A_FLAG: next_flags = next_flags & ~i_wdata; // R21
                default: next_temp = temp;
            endcase
        end
        // Vector acknowledge clears, but any event this cycle still lands
        next_flags[tc16_pkg::B_CAP] = next_flags[tc16_pkg::B_CAP] & ~i_vec_ack[3]; // R21
        next_flags[tc16_pkg::B_CMP_B] = next_flags[tc16_pkg::B_CMP_B] & ~i_vec_ack[2];
        next_flags[tc16_pkg::B_CMP_A] = next_flags[tc16_pkg::B_CMP_A] & ~i_vec_ack[1];
        next_flags[tc16_pkg::B_OVF] = next_flags[tc16_pkg::B_OVF] & ~i_vec_ack[0];
        if (tick && at_top && (is_phase ? 1'b0 : (is_fast || count == tc16_pkg::TOP_MAX))) begin
            next_flags[tc16_pkg::B_OVF] = 1'b1;
        end
        if (tick && is_phase && down && count == 16'h0000) begin
            next_flags[tc16_pkg::B_OVF] = 1'b1;
        end
        if (tick && !at_top && !is_phase && count == tc16_pkg::TOP_MAX) begin
            next_flags[tc16_pkg::B_OVF] = 1'b1;
        end
        if (tick && icr_top && at_top) begin
            next_flags[tc16_pkg::B_CAP] = 1'b1;
        end
        // Force never reaches the flags or the clear-on-match path
        next_flags[tc16_pkg::B_CMP_A] = next_flags[tc16_pkg::B_CMP_A] | hit[0]; // R9 R20
        next_flags[tc16_pkg::B_CMP_B] = next_flags[tc16_pkg::B_CMP_B] | hit[1]; // R9 R20
        if (cap_event && !icr_top) begin
            next_icr = count; // R3 R4
            next_flags[tc16_pkg::B_CAP] = 1'b1; // R3
        end
        next_flags = next_flags & tc16_pkg::IRQ_BITS;
        next_irq = {flags[tc16_pkg::B_CAP], flags[tc16_pkg::B_CMP_B], flags[tc16_pkg::B_CMP_A],
            flags[tc16_pkg::B_OVF]} & {imsk[tc16_pkg::B_CAP], imsk[tc16_pkg::B_CMP_B],
            imsk[tc16_pkg::B_CMP_A], imsk[tc16_pkg::B_OVF]} & {4{i_global_irq_en}}; // R16
    end

    always_ff @(posedge i_clock) begin
        if (!i_rst_n) begin
            ctrl_a <= tc16_pkg::RST_BYTE;
            ctrl_b <= tc16_pkg::RST_BYTE;
            imsk <= tc16_pkg::RST_BYTE;
            flags <= tc16_pkg::RST_BYTE;
            temp <= tc16_pkg::RST_BYTE;
            o_rdata <= tc16_pkg::RST_BYTE;
            count <= tc16_pkg::RST_WORD;
            icr <= tc16_pkg::RST_WORD;
            ocr[0] <= tc16_pkg::RST_WORD;
            ocr[1] <= tc16_pkg::RST_WORD;
            down <= 1'b0;
            block <= 1'b0;
            o_compare_out <= 2'b00;
            o_compare_out_en <= 2'b00;
            o_irq_req <= 4'h0;
        end else begin
            ctrl_a <= next_ctrl_a;
            ctrl_b <= next_ctrl_b;
            imsk <= next_imsk;
            flags <= next_flags;
            temp <= next_temp;
            o_rdata <= next_rdata;
            count <= next_count;
            icr <= next_icr;
            ocr <= next_ocr;
            down <= next_down;
            block <= next_block;
            o_compare_out <= next_out;
            o_compare_out_en <= next_out_en;
            o_irq_req <= next_irq;
        end
    end

    // ----------------------------------------
    // Checks
    // ----------------------------------------
    default clocking @(posedge i_clock); endclocking
    default disable iff (!i_rst_n);

    AST_FORCE_NO_FLAG: assert property (wr_c && !tick && i_wdata[tc16_pkg::B_FORCE_A] |=> // R9
        !$rose(flags[tc16_pkg::B_CMP_A]))
        else $error("forced compare set a flag");
    AST_CTRL_C_ZERO: assert property (i_rd && i_addr == tc16_pkg::A_CTRL_C |=> o_rdata == 8'h00) // R10
        else $error("control C read not zero");
    AST_MASK_UNUSED: assert property (i_rd && i_addr == tc16_pkg::A_MASK |=> // R17
        (o_rdata & ~tc16_pkg::IRQ_BITS) == 8'h00)
        else $error("unused mask bits read nonzero");
    AST_RETRIG_ZERO: assert property (i_rd && i_addr == tc16_pkg::A_CTRL_B |=> !o_rdata[5]) // R5
        else $error("retrigger bit read as one");
    AST_CAPTURE_COPY: assert property (cap_event && !icr_top && !i_wr |=> // R3
        icr == $past(count) && flags[tc16_pkg::B_CAP])
        else $error("capture did not copy counter");
    AST_CAPTURE_OFF: assert property (cap_event && icr_top && !i_wr && !tick |=> $stable(icr)) // R4
        else $error("capture active while capture register is TOP");
    AST_WRITE_BLOCKS: assert property (cnt_commit ##1 tick |-> hit == 2'b00) // R13
        else $error("match not blocked after counter write");
    AST_IRQ_GATE: assert property (##1 o_irq_req[0] == $past(flags[0] && imsk[0] && i_global_irq_en)) // R16
        else $error("overflow request disagrees with flag and enables");
    AST_LOW_COMMIT: assert property (i_wr && i_addr == tc16_pkg::A_OCA_L |=> // R22
        ocr[0] == {$past(temp), $past(i_wdata)})
        else $error("low byte write did not commit both bytes");

    // ----------------------------------------
    // Checks on byte access, forced and real matches, mask and retrigger writes, capture request
    // ----------------------------------------
    // Force must leave the count alone, else clear-on-match would fire
    AST_FORCE_NO_CLEAR: assert property (wr_c && !tick |=> count == $past(count)) // R9
        else $error("forced compare moved the counter");

    AST_FORCE_SET: assert property (force_cmp[0] && ctrl_a[7:6] == 2'b11 |=> o_compare_out[0]) // R8
        else $error("forced compare did not set output A");

    AST_MATCH_FLAG_A: assert property (hit[0] |=> flags[tc16_pkg::B_CMP_A]) // R20
        else $error("compare A match did not set its flag");

    AST_MATCH_FLAG_B: assert property (hit[1] |=> flags[tc16_pkg::B_CMP_B]) // R20
        else $error("compare B match did not set its flag");

    AST_LOW_READ: assert property (i_rd && i_addr == tc16_pkg::A_CNT_L |=> // R22
        temp == $past(count[15:8]))
        else $error("low byte read did not latch the high byte");

    AST_MASK_WRITE: assert property (i_wr && i_addr == tc16_pkg::A_MASK |=> // R17
        imsk == ($past(i_wdata) & tc16_pkg::IRQ_BITS))
        else $error("mask write kept unused bits");

    AST_RETRIG_WRITE: assert property (i_wr && i_addr == tc16_pkg::A_CTRL_B |=> !ctrl_b[tc16_pkg::B_RETRIG]) // R5
        else $error("retrigger bit stored as one");

    AST_CAP_IRQ: assert property (##1 o_irq_req[3] == $past(flags[5] && imsk[5] && i_global_irq_en)) // R16
        else $error("capture request disagrees with flag and enables");
endmodule
`default_nettype wire

//--- design/tc16_pkg.sv
// Constants shared by the 16-bit timer register set
// Operation
// R1: With filter on, capture input changes only after four equal samples.
// R2: Edge select zero captures on falling edge, one on rising edge.
// R3: A capture copies the counter into the capture register and sets its flag.
// R4: Modes using the capture register as TOP disable the capture function.
// R5: Software writes zero to the retrigger bit; it reads as zero.
// R6: Clock select: stop, divide by 1/8/64/256/1024, external falling or rising.
// R7: External modes count pin transitions even when the pin is an output.
// R8: In non-PWM modes a force bit applies an immediate match to the output.
// R9: A forced match sets no flag and never clears the counter.
// R10: Force bits are strobes; control C always reads as zero.
// R11: Software writes zero to force bits while in a PWM mode.
// R12: Sixteen-bit registers go through one shared high-byte latch.
// R13: A counter write blocks compare matches on the next timer clock.
// R14: Each compare register is compared with the counter every timer clock.
// R15: Capture source is the capture pin or the comparator output.
// R16: Interrupt requested only when enable, flag and global enable are set.
// R17: Unused mask bits read zero and ignore writes.
// R18: Waveform mode selects counting sequence and TOP; mode 13 is reserved.
// R19: Non-PWM output actions: disconnect, toggle, clear, set on match.
// R20: Compare flag sets on the timer clock after a match, never on force.
// R21: Flags clear on vector execution or by writing one.
// R22: Write high byte then low; low read latches the high byte.
package tc16_pkg;
    // ----------------------------------------
    // Register select codes
    // ----------------------------------------
    localparam logic [3:0] A_CTRL_A = 4'h0;
    localparam logic [3:0] A_CTRL_B = 4'h1;
    localparam logic [3:0] A_CTRL_C = 4'h2;
    localparam logic [3:0] A_CNT_L = 4'h3;
    localparam logic [3:0] A_CNT_H = 4'h4;
    localparam logic [3:0] A_OCA_L = 4'h5;
    localparam logic [3:0] A_OCA_H = 4'h6;
    localparam logic [3:0] A_OCB_L = 4'h7;
    localparam logic [3:0] A_OCB_H = 4'h8;
    localparam logic [3:0] A_ICR_L = 4'h9;
    localparam logic [3:0] A_ICR_H = 4'hA;
    localparam logic [3:0] A_MASK = 4'hB;
    localparam logic [3:0] A_FLAG = 4'hC;
    // ----------------------------------------
    // Field positions and reset values
    // ----------------------------------------
    localparam int B_NOISE = 7;
    localparam int B_EDGE = 6;
    localparam int B_RETRIG = 5;
    localparam int B_FORCE_A = 7;
    localparam int B_FORCE_B = 6;
    localparam int B_CAP = 5;
    localparam int B_CMP_B = 2;
    localparam int B_CMP_A = 1;
    localparam int B_OVF = 0;
    localparam logic [7:0] IRQ_BITS = 8'h27;
    localparam logic [7:0] RST_BYTE = 8'h00;
    localparam logic [15:0] RST_WORD = 16'h0000;
    localparam logic [15:0] TOP_8 = 16'h00FF;
    localparam logic [15:0] TOP_9 = 16'h01FF;
    localparam logic [15:0] TOP_10 = 16'h03FF;
    localparam logic [15:0] TOP_MAX = 16'hFFFF;
    // ----------------------------------------
    // Clock select and timing counts
    // ----------------------------------------
    localparam logic [2:0] CS_STOP = 3'h0;
    localparam logic [2:0] CS_DIV1 = 3'h1;
    localparam logic [2:0] CS_DIV8 = 3'h2;
    localparam logic [2:0] CS_DIV64 = 3'h3;
    localparam logic [2:0] CS_DIV256 = 3'h4;
    localparam logic [2:0] CS_DIV1024 = 3'h5;
    localparam logic [2:0] CS_EXT_FALL = 3'h6;
    localparam logic [2:0] CS_EXT_RISE = 3'h7;
    localparam logic [9:0] PRE_M8 = 10'h007;
    localparam logic [9:0] PRE_M64 = 10'h03F;
    localparam logic [9:0] PRE_M256 = 10'h0FF;
    localparam logic [9:0] PRE_M1024 = 10'h3FF;
    localparam int FILTER_LEN = 4;
endpackage

//--- design/tc16_prescale.sv
// Timer clock enable from I/O clock divider or external count pin
`timescale 1ns/1ns
`default_nettype none
module tc16_prescale (
    input wire logic i_clock,
    input wire logic i_rst_n,
    input wire logic [2:0] i_sel,
    input wire logic i_ext_count_pin,
    output logic o_tick
);
    logic [9:0] div, next_div;
    logic ext_prev, next_tick;

    // Pin is sampled whatever its direction, so software toggling counts too
    always_comb begin
        next_div = div + 10'h001;
        case (i_sel)
            tc16_pkg::CS_DIV1: next_tick = 1'b1; // R6
            tc16_pkg::CS_DIV8: next_tick = (div & tc16_pkg::PRE_M8) == tc16_pkg::PRE_M8;
            tc16_pkg::CS_DIV64: next_tick = (div & tc16_pkg::PRE_M64) == tc16_pkg::PRE_M64;
            tc16_pkg::CS_DIV256: next_tick = (div & tc16_pkg::PRE_M256) == tc16_pkg::PRE_M256;
            tc16_pkg::CS_DIV1024: next_tick = div == tc16_pkg::PRE_M1024;
            tc16_pkg::CS_EXT_FALL: next_tick = ext_prev & ~i_ext_count_pin; // R7
            tc16_pkg::CS_EXT_RISE: next_tick = ~ext_prev & i_ext_count_pin; // R7
            default: next_tick = 1'b0;
        endcase
    end

    always_ff @(posedge i_clock) begin
        if (!i_rst_n) begin
            div <= 10'h000;
            ext_prev <= 1'b0;
            o_tick <= 1'b0;
        end else begin
            div <= next_div;
            ext_prev <= i_ext_count_pin;
            o_tick <= next_tick;
        end
    end

    default clocking @(posedge i_clock); endclocking
    default disable iff (!i_rst_n);
    AST_STOPPED: assert property (i_sel == tc16_pkg::CS_STOP |=> !o_tick) // R6
        else $error("timer clock ticked while stopped");
    AST_EXT_RISE: assert property (i_sel == tc16_pkg::CS_EXT_RISE && !i_ext_count_pin ##1
        i_ext_count_pin && i_sel == tc16_pkg::CS_EXT_RISE |=> o_tick) // R7
        else $error("rising external edge not counted");
endmodule
`default_nettype wire

//--- design/tc16_capture.sv
// Capture input noise filter and edge detector
`timescale 1ns/1ns
`default_nettype none
module tc16_capture (
    input wire logic i_clock,
    input wire logic i_rst_n,
    input wire logic i_in,
    input wire logic i_filter_en,
    input wire logic i_edge_sel,
    output logic o_event
);
    logic [tc16_pkg::FILTER_LEN-1:0] smp;
    logic filt, prev, next_filt, level, next_event;

    always_comb begin
        next_filt = filt;
        if (&smp) begin
            next_filt = 1'b1; // R1
        end else if (~|smp) begin
            next_filt = 1'b0; // R1
        end
        level = i_filter_en ? filt : smp[0];
        next_event = i_edge_sel ? (level & ~prev) : (~level & prev); // R2
    end

    always_ff @(posedge i_clock) begin
        if (!i_rst_n) begin
            smp <= '0;
            filt <= 1'b0;
            prev <= 1'b0;
            o_event <= 1'b0;
        end else begin
            smp <= {smp[tc16_pkg::FILTER_LEN-2:0], i_in};
            filt <= next_filt;
            prev <= level;
            o_event <= next_event;
        end
    end

    default clocking @(posedge i_clock); endclocking
    default disable iff (!i_rst_n);
    AST_FILTER_FOUR: assert property ($changed(filt) |-> $past(smp) == {4{filt}}) // R1
        else $error("filter changed without four equal samples");
    AST_EDGE_RISE: assert property (i_edge_sel && !i_filter_en && $rose(smp[0]) ##1
        i_edge_sel && !i_filter_en |-> o_event) // R2
        else $error("rising edge did not trigger capture");
endmodule
`default_nettype wire

//--- test/tc16_testbench.sv
// Self-checking testbench for the 16-bit timer register set
`timescale 1ns/1ns
`default_nettype none
module testbench;
    typedef struct {int sel; logic [7:0] exp; string name;} tc16_chk_s;
    logic i_clock = 1'b0;
    logic i_rst_n = 1'b0;
    logic wr = 1'b0;
    logic rd = 1'b0;
    logic [3:0] addr = 4'h0;
    logic [7:0] wdata = 8'h00;
    logic cap_pin = 1'b0;
    logic ext_pin = 1'b0;
    logic gie = 1'b0;
    logic [3:0] vack = 4'h0;
    logic cmp_out = 1'b0;
    logic cmp_sel = 1'b0;
    logic [7:0] rdata;
    logic [3:0] irq;
    logic [1:0] cout, cout_en;
    logic rd_d = 1'b0;
    logic [15:0] rnd;
    int miscompares = 0;
    int n_compared = 0;
    int seed;
    tc16_chk_s q[$];
    tc16_chk_s c;

    tc16_regs i_dut (.i_clock(i_clock), .i_rst_n(i_rst_n), .i_addr(addr), .i_wr(wr), .i_rd(rd),
        .i_wdata(wdata), .o_rdata(rdata), .i_capture_pin(cap_pin), .i_comparator_out(cmp_out),
        .i_capture_from_comparator(cmp_sel), .i_ext_count_pin(ext_pin), .i_global_irq_en(gie),
        .i_vec_ack(vack), .o_irq_req(irq), .o_compare_out(cout), .o_compare_out_en(cout_en));

    initial begin
        forever #10 i_clock = ~i_clock;
    end

    // ----------------------------------------
    // Bus tasks and result watcher
    // ----------------------------------------
    task automatic check(input string n, input logic [7:0] seen, input logic [7:0] exp);
        n_compared++;
        if (seen !== exp) begin
            miscompares++;
            $display("[ERR] %s expected %h seen %h", n, exp, seen);
        end
    endtask

    task automatic wr_reg(input logic [3:0] a, input logic [7:0] d);
        @(posedge i_clock);
        #1 addr = a;
        wdata = d;
        wr = 1'b1;
        @(posedge i_clock);
        #1 wr = 1'b0;
    endtask

    task automatic rd_reg(input logic [3:0] a, input logic [7:0] e, input string n);
        q.push_back('{0, e, n});
        @(posedge i_clock);
        #1 addr = a;
        rd = 1'b1;
        @(posedge i_clock);
        #1 rd = 1'b0;
        @(posedge i_clock);
    endtask

    // Pin results are noted only while no read is outstanding
    task automatic pin(input int s, input logic [7:0] e, input string n);
        q.push_back('{s, e, n});
        @(posedge i_clock);
        @(posedge i_clock);
    endtask

    task automatic wr16(input logic [3:0] lo, input logic [15:0] v);
        wr_reg(lo + 4'h1, v[15:8]);
        wr_reg(lo, v[7:0]);
    endtask

    always @(posedge i_clock) rd_d <= rd;

    always @(negedge i_clock) begin
        if (q.size() > 0 && (rd_d || q[0].sel != 0)) begin
            c = q.pop_front();
            check(c.name, (c.sel == 0) ? rdata : (c.sel == 1) ? {4'h0, irq} : {4'h0, cout_en, cout}, c.exp);
        end
    end

    task automatic stop_test;
        $display("compared %0d mismatches %0d", n_compared, miscompares);
        if (miscompares == 0 && n_compared > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask

    initial begin
        #400000;
        miscompares++;
        stop_test;
    end

    // ----------------------------------------
    // Scenarios
    // ----------------------------------------
    initial begin
        seed = 32'h636ac81f;
        repeat (3) @(posedge i_clock);
        #1 i_rst_n = 1'b1;
        for (int k = 0; k < 14; k++) rd_reg(k[3:0], 8'h00, "reset value");
        wr_reg(tc16_pkg::A_CTRL_B, 8'hFF);
        rd_reg(tc16_pkg::A_CTRL_B, 8'hDF, "ctrl_b");
        wr_reg(tc16_pkg::A_CTRL_B, 8'h00);
        wr_reg(tc16_pkg::A_MASK, 8'hFF);
        rd_reg(tc16_pkg::A_MASK, 8'h27, "mask");
        wr_reg(4'hE, 8'hFF);
        rd_reg(4'hE, 8'h00, "unmapped");
        wr_reg(tc16_pkg::A_MASK, 8'h02);
        wr_reg(tc16_pkg::A_CTRL_A, 8'h40);
        wr_reg(tc16_pkg::A_CTRL_C, 8'hC0);
        rd_reg(tc16_pkg::A_CTRL_C, 8'h00, "ctrl_c");
        pin(2, 8'h05, "forced out");
        rd_reg(tc16_pkg::A_FLAG, 8'h00, "flag after force");
        rnd = 16'($random(seed)) | 16'h8000;
        wr16(tc16_pkg::A_OCB_L, rnd);
        rd_reg(tc16_pkg::A_OCB_L, rnd[7:0], "cmp_b low");
        rd_reg(tc16_pkg::A_OCB_H, rnd[15:8], "cmp_b high");
        wr16(tc16_pkg::A_OCA_L, 16'h0010);
        wr16(tc16_pkg::A_CNT_L, 16'h0000);
        gie = 1'b1;
        wr_reg(tc16_pkg::A_CTRL_B, {5'h00, tc16_pkg::CS_DIV1});
        repeat (40) @(posedge i_clock);
        wr_reg(tc16_pkg::A_CTRL_B, 8'h00);
        rd_reg(tc16_pkg::A_FLAG, 8'h02, "match flag");
        pin(1, 8'h02, "irq");
        pin(2, 8'h04, "toggled out");
        wr_reg(tc16_pkg::A_FLAG, 8'h02);
        rd_reg(tc16_pkg::A_FLAG, 8'h00, "flag cleared");
        pin(1, 8'h00, "irq cleared");
        wr_reg(tc16_pkg::A_CTRL_B, {5'h00, tc16_pkg::CS_DIV1});
        wr16(tc16_pkg::A_CNT_L, 16'h0010);
        repeat (8) @(posedge i_clock);
        wr_reg(tc16_pkg::A_CTRL_B, 8'h00);
        rd_reg(tc16_pkg::A_FLAG, 8'h00, "blocked match");
        wr_reg(tc16_pkg::A_CTRL_B, {5'h00, tc16_pkg::CS_EXT_RISE});
        wr16(tc16_pkg::A_CNT_L, 16'h0000);
        repeat (6) begin
            repeat (4) @(posedge i_clock);
            #1 ext_pin = ~ext_pin;
        end
        repeat (4) @(posedge i_clock);
        rd_reg(tc16_pkg::A_CNT_L, 8'h03, "ext count");
        wr_reg(tc16_pkg::A_CTRL_B, 8'h40);
        wr16(tc16_pkg::A_CNT_L, 16'h1234);
        #1 cap_pin = 1'b1;
        repeat (6) @(posedge i_clock);
        rd_reg(tc16_pkg::A_ICR_L, 8'h34, "capture low");
        rd_reg(tc16_pkg::A_ICR_H, 8'h12, "capture high");
        rd_reg(tc16_pkg::A_FLAG, 8'h20, "capture flag");
        wr_reg(tc16_pkg::A_CTRL_B, 8'h80);
        wr16(tc16_pkg::A_CNT_L, 16'h0ABC);
        #1 cap_pin = 1'b0;
        repeat (2) @(posedge i_clock);
        #1 cap_pin = 1'b1;
        repeat (10) @(posedge i_clock);
        rd_reg(tc16_pkg::A_ICR_L, 8'h34, "glitch filtered");
        #1 cap_pin = 1'b0;
        repeat (12) @(posedge i_clock);
        rd_reg(tc16_pkg::A_ICR_L, 8'hBC, "filtered fall");
        #1 vack = 4'h8;
        @(posedge i_clock);
        #1 vack = 4'h0;
        rd_reg(tc16_pkg::A_FLAG, 8'h00, "vector cleared");
        wr_reg(tc16_pkg::A_CTRL_B, 8'h40);
        wr16(tc16_pkg::A_CNT_L, 16'h0055);
        #1 cmp_sel = 1'b1;
        @(posedge i_clock);
        #1 cmp_out = 1'b1;
        repeat (4) @(posedge i_clock);
        rd_reg(tc16_pkg::A_ICR_L, 8'h55, "comparator capture");
        stop_test;
    end
endmodule
`default_nettype wire
